// ===== hw/ivr_core.sv
/*
 * Interrupt level encoding, daisy-chain selection and acknowledge vector response.
 * Assumes request lines and levels come from outside, synchronous to sys_clk, and
 * that the processor side frames each acknowledge cycle with start and finish pulses.
 */
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module ivr_core
    import ivr_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire ivr_bus_req_t          bus_req,
    output logic [31:0]                reg_rdata,
    input  wire logic [63:0]           int_req,
    input  wire logic [63:0][2:0]      int_level,
    input  wire logic [7:1]            vme_irq_line_n,
    input  wire logic [7:1][2:0]       vme_level,
    output logic [2:0]                 cpu_priority_level_lines_n,
    input  wire ivr_iack_req_t         iack_req,
    output logic [7:0]                 cpu_data_upper_byte,
    output logic                       cpu_data_oe,
    output logic                       cpu_iack_dtack,
    output logic [3:0]                 local_ack_strobe_n,
    input  wire logic [7:0]            local_io_data,
    output logic                       vme_iack_req,
    output logic [2:0]                 vme_iack_num,
    input  wire logic                  vme_vec_valid,
    input  wire logic [7:0]            vme_data_low_byte,
    output logic [1:0]                 control_reg_three_aux
);

    typedef struct packed {
        logic [7:0]  mode;
        logic [3:0]  control_reg_three;
        ivr_state_t  fsm;
        logic [7:0]  cnt;
        logic        from_vme;
        logic [7:0]  vec;
        logic [3:0]  lack_n;
        logic [2:0]  vnum;
        logic [7:0]  last_vec;
        logic [7:0]  rdata;
    } ivr_regs_t;

    ivr_regs_t   s;
    ivr_regs_t   next_s;
    logic [70:0] req_all;
    logic [70:0][2:0] lvl_all;
    logic [2:0]  top_level;
    logic [7:0]  pick;

    // Build an internal vector from the two page bits of control register three and a six-bit number.
    function automatic logic [7:0] ivr_make_vec(input logic [3:0] control_reg_three, input logic [5:0] num);
        ivr_make_vec = {control_reg_three[IVR_PAGE_LSB+1:IVR_PAGE_LSB], num}; // see [R16] [R21]
    endfunction

    // Lowest index wins among pending sources at the wanted level.
    function automatic logic [7:0] ivr_pick(input logic [70:0] req, input logic [70:0][2:0] lvl,
                                            input logic [2:0] want);
        logic [7:0] r;
        r = 8'h00;
        for (int i = IVR_NUM_SRC - 1; i >= 0; i--)
        begin
            if (req[i] && lvl[i] == want && want != 3'h0)
            begin
                r = {1'b1, 7'(i)}; // see [R15]
            end
        end
        return r;
    endfunction

    // Gather requests; reserved internal numbers and level zero never count.
    always_comb
    begin
        for (int i = 0; i < 64; i++)
        begin
            req_all[i] = int_req[i] && IVR_CHAN_VALID[i] && int_level[i] != 3'h0; // see [R14] [R17]
            lvl_all[i] = int_level[i];
        end
        for (int k = 0; k < 7; k++)
        begin
            // VIRQ7 sits first after the internal space, VME_IRQ_LINE last.
            req_all[64 + k] = !vme_irq_line_n[7 - k] && vme_level[7 - k] != 3'h0; // see [R14]
            lvl_all[64 + k] = vme_level[7 - k];
        end
    end

    // Highest pending level, seven down to one.
    always_comb
    begin
        top_level = 3'h0;
        for (int l = 1; l <= 7; l++)
        begin
            for (int i = 0; i < IVR_NUM_SRC; i++)
            begin
                if (req_all[i] && lvl_all[i] == 3'(l))
                begin
                    top_level = 3'(l); // see [R12]
                end
            end
        end
    end

    // Decode of the acknowledged level; relies on sources holding requests stable.
    assign pick = ivr_pick(req_all, lvl_all, iack_req.level); // see [R9]

    // Next-state logic: register port, acknowledge sequencer and local strobes.
    always_comb
    begin
        logic [6:0] idx;
        logic [1:0] cmode;
        logic [1:0] ch;
        idx    = pick[6:0];
        cmode  = 2'h0;
        ch     = 2'h0;
        next_s = s;
        next_s.rdata = 8'h00;

        // Register writes.
        if (bus_req.wr)
        begin
            if (bus_req.addr == IVR_ADDR_MODE)
            begin
                next_s.mode = bus_req.wdata[7:0]; // see [R1]
            end
            if (bus_req.addr == IVR_ADDR_CONTROL_REG_THREE)
            begin
                next_s.control_reg_three = bus_req.wdata[3:0];
            end
            if (bus_req.addr == IVR_ADDR_PAGE)
            begin
                // Page-only alias so page updates cannot disturb the two low control bits.
                next_s.control_reg_three[IVR_PAGE_LSB+1:IVR_PAGE_LSB] = bus_req.wdata[IVR_PAGE_LSB+1:IVR_PAGE_LSB]; // see [R20]
            end
        end

        // Register reads; unmapped addresses and missing bits read as zero.
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                IVR_ADDR_MODE:   next_s.rdata = s.mode;
                IVR_ADDR_CONTROL_REG_THREE:   next_s.rdata = {4'h0, s.control_reg_three};
                IVR_ADDR_PAGE:   next_s.rdata = {4'h0, s.control_reg_three[IVR_PAGE_LSB+1:IVR_PAGE_LSB], 2'h0};
                IVR_ADDR_STATUS: next_s.rdata = s.last_vec;
                default:         next_s.rdata = 8'h00;
            endcase
        end

        unique case (s.fsm)
            IVR_IDLE:
            begin
                if (iack_req.start)
                begin
                    next_s.from_vme = 1'b0;
                    if (!pick[7])
                    begin
                        // Nothing decodable: the virtual empty channel answers at once.
                        next_s.vec = ivr_make_vec(s.control_reg_three, IVR_EMPTY_NUM); // see [R10] [R11]
                        next_s.fsm = IVR_DRIVE;
                    end
                    else if (idx >= IVR_VME_BASE)
                    begin
                        next_s.vnum     = 3'(7 - (idx - IVR_VME_BASE));
                        next_s.from_vme = 1'b1; // see [R8]
                        next_s.fsm      = IVR_FETCH;
                    end
                    else if (idx[5:2] == IVR_LOCAL_CHAN_FOUR_NUM[5:2])
                    begin
                        ch    = idx[1:0];
                        cmode = s.mode[2*ch +: 2];
                        next_s.lack_n[ch] = 1'b0; // see [R6]
                        unique case (cmode)
                            IVR_MODE_INT:
                            begin
                                next_s.vec = ivr_make_vec(s.control_reg_three, idx[5:0]); // see [R2]
                                next_s.fsm = IVR_DRIVE;
                            end
                            IVR_MODE_NONE:
                            begin
                                next_s.fsm = IVR_PASS; // see [R3]
                            end
                            IVR_MODE_EXT1U:
                            begin
                                next_s.cnt = IVR_ACC_LONG_CY; // see [R4]
                                next_s.fsm = IVR_FETCH;
                            end
                            IVR_MODE_EXT5H:
                            begin
                                next_s.cnt = IVR_ACC_SHRT_CY; // see [R5]
                                next_s.fsm = IVR_FETCH;
                            end
                        endcase
                    end
                    else
                    begin
                        next_s.vec = ivr_make_vec(s.control_reg_three, idx[5:0]); // see [R16]
                        next_s.fsm = IVR_DRIVE;
                    end
                end
            end
            IVR_FETCH:
            begin
                if (s.from_vme)
                begin
                    if (vme_vec_valid)
                    begin
                        next_s.vec = vme_data_low_byte; // see [R8]
                        next_s.fsm = IVR_DRIVE;
                    end
                end
                else if (s.cnt == 8'h01)
                begin
                    // The interrupter has had the whole access time to drive its vector.
                    next_s.vec = local_io_data; // see [R7] [R22]
                    next_s.fsm = IVR_DRIVE;
                end
                else
                begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            IVR_DRIVE:
            begin
                next_s.last_vec = s.vec;
            end
            IVR_PASS:
            begin
                next_s.last_vec = s.last_vec;
            end
        endcase

        // Any acknowledge cycle ending returns state, strobes, bus request and counter to rest.
        if (iack_req.finish && s.fsm != IVR_IDLE)
        begin
            next_s.fsm      = IVR_IDLE;
            next_s.lack_n   = 4'hF;
            next_s.from_vme = 1'b0;
            next_s.cnt      = 8'h00;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s          <= '0;
            s.mode     <= IVR_MODE_RESET;
            s.control_reg_three     <= IVR_CONTROL_REG_THREE_RESET; // see [R18]
            s.fsm      <= IVR_IDLE;
            s.lack_n   <= 4'hF;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Priority lines are active low toward the processor.
    assign cpu_priority_level_lines_n = ~top_level; // see [R13]

    // The vector register drives the upper CPU byte only while answering.
    assign cpu_data_upper_byte = s.vec;
    assign cpu_data_oe         = (s.fsm == IVR_DRIVE); // see [R21] [R22]
    assign cpu_iack_dtack      = (s.fsm == IVR_DRIVE); // see [R10]
    assign local_ack_strobe_n  = s.lack_n;
    assign vme_iack_req        = (s.fsm == IVR_FETCH) && s.from_vme;
    assign vme_iack_num        = s.vnum;
    assign reg_rdata           = {24'h000000, s.rdata};
    assign control_reg_three_aux            = s.control_reg_three[IVR_AUX_LSB+1:IVR_AUX_LSB];

endmodule

// ===== hw/ivr_pkg.sv
/*
 * Shared constants and carrier types for the interrupt vector response block.
 * Assumes a 100 MHz sys_clk and a register master that keeps the plain strobe port.
 */
// Contract
// [R1] Mode register: channel 7 bits 7..6, 6 bits 5..4, 5 bits 3..2, 4 bits 1..0.
// [R2] Mode 00: internal vector 34h..37h on upper CPU byte, assert channel acknowledge.
// [R3] Mode 01: no vector, no cycle end, only assert channel acknowledge early.
// [R4] Mode 10: assert acknowledge, fetch vector from local I/O bus in 1 us, present it.
// [R5] Mode 11: as mode 10 but with a 500 ns fetch time.
// [R6] Acknowledging local channel 4..7 drives its acknowledge output low.
// [R7] External interrupter drives its vector on local I/O data while acknowledged.
// [R8] VME interrupter supplies vector on low VME byte; device passes it to CPU.
// [R9] Sources hold requests stable until the acknowledge cycle has decoded them.
// [R10] No decodable source: answer empty vector 3Fh so the cycle never times out.
// [R11] Empty channel is virtual: no source, no control or status register.
// [R12] Seven levels, level 7 highest, level 1 lowest.
// [R13] Highest pending level encoded on the three processor priority lines.
// [R14] A channel programmed to level zero never interrupts the processor.
// [R15] Same level: lowest vector number first; level beats daisy-chain position.
// [R16] Internal vector: 6-bit channel number low, 2-bit common page high.
// [R17] Internal vector space is 64 numbers; unassigned numbers are reserved.
// [R18] Page resets to zero; boot software must program a non-zero page.
// [R19] Software avoids page 11b, reserved for boot software and expansion.
// [R20] Page sits in control register three bits 3..2; page writes keep bits 1..0.
// [R21] Internal response: number on CPU data 24..29, page on 30..31.
// [R22] After an external fetch, hold the vector on the CPU bus and end the cycle.
package ivr_pkg;

    // Register byte addresses.
    localparam logic [31:0] IVR_ADDR_MODE   = 32'hFFD00334;
    localparam logic [31:0] IVR_ADDR_CONTROL_REG_THREE   = 32'hFFD00250;
    localparam logic [31:0] IVR_ADDR_PAGE   = 32'hFFD00338;
    localparam logic [31:0] IVR_ADDR_STATUS = 32'hFFD0033C;

    // Reset values and field positions.
    localparam logic [7:0] IVR_MODE_RESET = 8'h00;
    localparam logic [3:0] IVR_CONTROL_REG_THREE_RESET = 4'h0;
    localparam int         IVR_PAGE_LSB   = 2;
    localparam int         IVR_AUX_LSB    = 0;

    // Vector numbers of the block.
    localparam logic [5:0]  IVR_EMPTY_NUM   = 6'h3F;
    localparam logic [5:0]  IVR_LOCAL_CHAN_FOUR_NUM  = 6'h34;
    localparam logic [6:0]  IVR_VME_BASE    = 7'h40;
    localparam logic [63:0] IVR_CHAN_VALID  = 64'h00FF3FF1_000000FF;
    localparam int          IVR_NUM_SRC     = 71;

    // Response mode codes of one local channel.
    localparam logic [1:0] IVR_MODE_INT   = 2'h0;
    localparam logic [1:0] IVR_MODE_NONE  = 2'h1;
    localparam logic [1:0] IVR_MODE_EXT1U = 2'h2;
    localparam logic [1:0] IVR_MODE_EXT5H = 2'h3;

    // Local I/O fetch times.
    localparam int         IVR_CLK_NS      = 10;
    localparam int         IVR_ACC_LONG_NS = 1000;
    localparam int         IVR_ACC_SHRT_NS = 500;
    localparam logic [7:0] IVR_ACC_LONG_CY = 8'(IVR_ACC_LONG_NS / IVR_CLK_NS);
    localparam logic [7:0] IVR_ACC_SHRT_CY = 8'(IVR_ACC_SHRT_NS / IVR_CLK_NS);

    typedef enum logic [1:0] {
        IVR_IDLE  = 2'h0,
        IVR_FETCH = 2'h1,
        IVR_DRIVE = 2'h3,
        IVR_PASS  = 2'h2
    } ivr_state_t;

    // Register port request from software.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ivr_bus_req_t;

    // Acknowledge cycle request from the processor side.
    typedef struct packed {
        logic       start;
        logic [2:0] level;
        logic       finish;
    } ivr_iack_req_t;

endpackage

// ===== tb/ivr_chk.sv
/* Concurrent checks on the level and acknowledge ports of ivr_core.
   Assumes it is bound to ivr_core and shares its sys_clk and nrst. */
`timescale 1ns/1ns
module ivr_chk
    import ivr_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             nrst,
    input wire logic [63:0][2:0] int_level,
    input wire logic [7:1]       vme_irq_line_n,
    input wire logic [7:1][2:0]  vme_level,
    input wire logic [2:0]       cpu_priority_level_lines_n,
    input wire ivr_iack_req_t    iack_req,
    input wire logic [7:0]       cpu_data_upper_byte,
    input wire logic             cpu_data_oe,
    input wire logic             cpu_iack_dtack,
    input wire logic [3:0]       local_ack_strobe_n,
    input wire logic             vme_iack_req,
    input wire logic             vme_vec_valid,
    input wire logic [7:0]       vme_data_low_byte
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    oe_dtack_a: assert property (cpu_data_oe == cpu_iack_dtack)
        else $error("vector drive and cycle end disagree");
    dtack_hold_a: assert property (cpu_iack_dtack && !iack_req.finish |=> cpu_iack_dtack)
        else $error("cycle end dropped before finish");
    dtack_end_a: assert property (cpu_iack_dtack && iack_req.finish |=> !cpu_iack_dtack)
        else $error("cycle end held after finish");
    vec_hold_a: assert property (cpu_iack_dtack && !iack_req.finish |=> $stable(cpu_data_upper_byte))
        else $error("vector changed while driven");
    strobe_one_a: assert property ($onehot0(~local_ack_strobe_n))
        else $error("more than one local acknowledge low");
    level_off_a: assert property (int_level == '0 && vme_level == '0 |-> cpu_priority_level_lines_n == 3'h7)
        else $error("level lines active with all levels zero");
    level_top_a: assert property (!vme_irq_line_n[7] && vme_level[7] == 3'h7 |-> cpu_priority_level_lines_n == 3'h0)
        else $error("level seven not shown on level lines");
    vme_pass_a: assert property (vme_iack_req && vme_vec_valid |=>
        cpu_iack_dtack && cpu_data_upper_byte == $past(vme_data_low_byte))
        else $error("bus vector not passed on");
    strobe_vme_a: assert property (!(&local_ack_strobe_n) |-> !vme_iack_req)
        else $error("local and bus acknowledge together");

    // Main scenarios that the bench should reach.
    c_int: cover property (!(&local_ack_strobe_n) && cpu_iack_dtack);
    c_none: cover property (!(&local_ack_strobe_n) && !cpu_iack_dtack);
    c_vme: cover property (vme_iack_req && vme_vec_valid);
endmodule

// ===== tb/ivr_far.sv
/* Far side model: a local I/O interrupter and a bus interrupter.
   Assumes the acknowledge strobes and bus request come from ivr_core. */
`timescale 1ns/1ns
module ivr_far
(
    input wire logic       sys_clk,
    input wire logic [3:0] local_ack_strobe_n,
    input wire logic [7:0] loc_vec,
    input wire logic       vme_iack_req,
    input wire logic [7:0] vme_vec,
    input wire logic [3:0] vme_dly,
    output logic [7:0]     local_io_data,
    output logic           vme_vec_valid,
    output logic [7:0]     vme_data_low_byte
);
    logic [3:0] cnt;
    logic [7:0] last_loc = 8'h00;
    logic [7:0] last_vme = 8'h00;

    // Released lines toggle each cycle so no stale vector can pass for a good one.
    assign local_io_data = (&local_ack_strobe_n) ? ~last_loc : loc_vec;
    assign vme_vec_valid = vme_iack_req && (cnt == vme_dly);
    assign vme_data_low_byte = vme_vec_valid ? vme_vec : ~last_vme;

    // Wait count lets the bus interrupter answer promptly or slowly.
    always_ff @(posedge sys_clk)
    begin
        cnt <= vme_iack_req ? cnt + 4'h1 : 4'h0;
        last_loc <= local_io_data;
        last_vme <= vme_data_low_byte;
    end
endmodule

// ===== tb/ivr_core_test.sv
/* Self-checking bench for ivr_core: register port, level lines and acknowledge cycles.
   Assumes ivr_far answers on the far side and ivr_chk is bound to the design. */
`timescale 1ns/1ns
module ivr_core_test;
    import ivr_pkg::*;
    logic             sys_clk, nrst, cpu_data_oe, cpu_iack_dtack, vme_iack_req, vme_vec_valid;
    ivr_bus_req_t     bus_req;
    ivr_iack_req_t    iack_req;
    logic [31:0]      reg_rdata;
    logic [63:0]      int_req;
    logic [63:0][2:0] int_level;
    logic [7:1]       vme_irq_line_n;
    logic [7:1][2:0]  vme_level;
    logic [2:0]       cpu_priority_level_lines_n, vme_iack_num;
    logic [7:0]       cpu_data_upper_byte, local_io_data, vme_data_low_byte, loc_vec, vme_vec;
    logic [3:0]       local_ack_strobe_n, vme_dly;
    logic [1:0]       control_reg_three_aux;
    int               bad_count, n_tests, cyc;

    ivr_core dut (.*);
    ivr_far u_far (.*);

    // Free running 100 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, exp);
    endtask

    // One acknowledge cycle; a count of 150 means the block never ended it.
    task automatic ack(input logic [2:0] lvl, input logic [7:0] vec, input logic [3:0] strb, input int n_exp);
        int n;
        @(posedge sys_clk);
        iack_req <= '{start: 1'b1, level: lvl, finish: 1'b0};
        @(posedge sys_clk);
        iack_req.start <= 1'b0;
        #1 n = 0;
        while (cpu_iack_dtack !== 1'b1 && n < 150)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("cycles", n, n_exp);
        chk("strobe", local_ack_strobe_n, strb);
        chk("oe", cpu_data_oe, 32'(n_exp < 150));
        if (n < 150)
            chk("vector", cpu_data_upper_byte, vec);
        @(posedge sys_clk);
        iack_req.finish <= 1'b1;
        @(posedge sys_clk);
        iack_req.finish <= 1'b0;
        #1 chk("idle", {cpu_data_oe, cpu_iack_dtack, local_ack_strobe_n}, 6'h0F);
    endtask

    // Reset, then the register port, the level lines and every kind of acknowledge response.
    initial
    begin
        nrst = 1'b0;
        bus_req = '0;
        iack_req = '0;
        int_req = '0;
        int_level = '0;
        vme_irq_line_n = 7'h7F;
        vme_level = '0;
        loc_vec = 8'hA5;
        vme_vec = 8'h9C;
        vme_dly = 4'h0;
        bad_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        fork
            begin
                rd(IVR_ADDR_MODE, 32'h0);
                rd(IVR_ADDR_CONTROL_REG_THREE, 32'h0);
                chk("levels", cpu_priority_level_lines_n, 3'h7);
                wr(IVR_ADDR_MODE, 32'hE4);
                rd(IVR_ADDR_MODE, 32'hE4);
                rd(32'hFFD00400, 32'h0);
                // Software leaves page zero and never picks the reserved top page.
                wr(IVR_ADDR_CONTROL_REG_THREE, 32'hB);
                wr(IVR_ADDR_PAGE, 32'h4);
                rd(IVR_ADDR_CONTROL_REG_THREE, 32'h7);
                rd(IVR_ADDR_PAGE, 32'h4);
                chk("aux", control_reg_three_aux, 2'h3);
                // Higher level on a later channel, two tied on level 3; requests stay up through each cycle.
                @(posedge sys_clk);
                int_req <= 64'h0013_0001_0000_0000;
                int_level[6'h34] <= 3'h5;
                int_level[6'h20] <= 3'h3;
                int_level[6'h30] <= 3'h3;
                #1 chk("levels", cpu_priority_level_lines_n, 3'h2);
                ack(3'h5, 8'h74, 4'hE, 0);
                ack(3'h3, 8'h60, 4'hF, 0);
                ack(3'h2, 8'h7F, 4'hF, 0);
                @(posedge sys_clk);
                int_req <= 64'h00E0_0000_0000_0000;
                int_level <= '0;
                #1 chk("levels", cpu_priority_level_lines_n, 3'h7);
                @(posedge sys_clk);
                int_level[6'h35] <= 3'h4;
                int_level[6'h36] <= 3'h6;
                int_level[6'h37] <= 3'h7;
                ack(3'h4, 8'h00, 4'hD, 150);
                ack(3'h6, 8'hA5, 4'hB, 100);
                ack(3'h7, 8'hA5, 4'h7, 50);
                @(posedge sys_clk);
                int_req <= '0;
                vme_irq_line_n[7] <= 1'b0;
                vme_level[7] <= 3'h7;
                #1 chk("levels", cpu_priority_level_lines_n, 3'h0);
                for (int d = 0; d < 8; d += 4)
                begin
                    vme_dly <= 4'(d);
                    ack(3'h7, 8'h9C, 4'hF, 1 + d);
                end
                chk("vme line", vme_iack_num, 3'h7);
                // Line 2, next to last in the chain, answers only when its own level is acknowledged.
                @(posedge sys_clk);
                vme_irq_line_n[2] <= 1'b0;
                vme_level[2] <= 3'h2;
                vme_dly <= 4'h0;
                ack(3'h2, 8'h9C, 4'hF, 1);
                chk("vme line", vme_iack_num, 3'h2);
                wr(IVR_ADDR_STATUS, 32'h0);
                rd(IVR_ADDR_STATUS, 32'h9C);
            end
            begin
                // A hang is cut short well above the expected run length.
                while (cyc < 4000)
                begin
                    @(posedge sys_clk);
                    cyc++;
                end
                bad_count++;
            end
        join_any
        print_verdict();
    end
endmodule

bind ivr_core ivr_chk u_chk (.*);
